// file: host_model.sv
// Purpose: Host controller model on the register port.
// Assumes: Strobes change by non-blocking assignment after a rising edge.
// Notes:   Released write data shows the inverse, never a stale copy.
`timescale 1ns/1ps
`default_nettype none
module host_model
(
	input  wire logic       ref_clk,
	input  wire logic [7:0] rdata,
	output var  logic [2:0] addr,
	output var  logic [7:0] wdata,
	output var  logic       wr_stb,
	output var  logic       rd_stb
);
	// Idle bus at time zero
	initial
	begin
		addr = 3'h0;
		wdata = 8'h00;
		wr_stb = 1'b0;
		rd_stb = 1'b0;
	end
	// One-cycle write; host programs every setting it relies on
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge ref_clk);
		wr_stb <= 1'b0;
		wdata <= ~d;
	endtask
	// Data stand only in the cycle after the strobe
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge ref_clk);
		rd_stb <= 1'b0;
		#1;
		d = rdata;
	endtask
endmodule
`default_nettype wire

// file: osd_attr_state.sv
// Purpose: Internally held display attributes, changed only by display codes.
// Assumes: Code strobes come from the display datapath, one cycle long.
// Notes:   A space code updates aux and background; a return code updates size.
`timescale 1ns/1ps
`default_nettype none

module osd_attr_state
(
	input  wire logic       ref_clk,
	input  wire logic       rst_b,
	input  wire logic       clk_en,
	input  wire logic       space_code,
	input  wire logic       space_aux,
	input  wire logic [3:0] space_bg,
	input  wire logic       return_code,
	input  wire logic [1:0] return_size,
	input  wire logic       end_code,
	input  wire logic       restart,
	output var  logic       aux_attr_out,
	output var  logic [3:0] bg_attr,
	output var  logic       char_size_hi,
	output var  logic       char_size_lo,
	output var  logic       end_attr
);

	logic       next_aux;
	logic [3:0] next_bg;
	logic [1:0] next_size;
	logic       next_end;

	// Attributes change only on their own codes
	always_comb
	begin
		next_aux  = aux_attr_out;
		next_bg   = bg_attr;
		next_size = {char_size_hi, char_size_lo};
		next_end  = end_attr;
		if (space_code)
		begin
			next_aux = space_aux;
			next_bg  = space_bg;
		end
		if (return_code)
			next_size = return_size;
		// Restart of a frame wins so a stale end mark never blocks fetching
		if (end_code)
			next_end = 1'h1;
		if (restart)
			next_end = 1'h0;
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			aux_attr_out <= osd_defaults_pkg::ATTR_AUX_RST;
			bg_attr      <= osd_defaults_pkg::ATTR_BG_RST;
			char_size_hi <= osd_defaults_pkg::ATTR_SIZE_RST[1];
			char_size_lo <= osd_defaults_pkg::ATTR_SIZE_RST[0];
			end_attr     <= osd_defaults_pkg::ATTR_END_RST;
		end
		else if (clk_en)
		begin
			aux_attr_out <= next_aux;
			bg_attr      <= next_bg;
			char_size_hi <= next_size[1];
			char_size_lo <= next_size[0];
			end_attr     <= next_end;
		end
	end

endmodule
`default_nettype wire

// file: osd_ctrl_reg.sv
// Purpose: One host-writable control register with reset default and bit mask.
// Assumes: Writes are single-cycle strobes synchronous to ref_clk.
// Notes:   Bits outside the mask hold zero so unused bits read as zero.
`timescale 1ns/1ps
`default_nettype none

module osd_ctrl_reg
#(
	parameter logic [7:0] RST_VAL = 8'h00,
	parameter logic [7:0] MASK    = 8'hFF
)
(
	input  wire logic       ref_clk,
	input  wire logic       rst_b,
	input  wire logic       clk_en,
	input  wire logic       wr,
	input  wire logic [7:0] wdata,
	output var  logic [7:0] value
);

	logic [7:0] next_value;

	// Hold the default until a write lands
	always_comb
	begin
		next_value = value;
		if (wr)
			next_value = wdata & MASK;
	end

	// Default loaded while reset is held
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			value <= RST_VAL;
		else if (clk_en)
			value <= next_value;
	end

endmodule
`default_nettype wire

// file: osd_defaults_checker.sv
// Purpose: Assertions on the control and attribute bank ports.
// Assumes: One clock, asynchronous active-low reset.
// Notes:   Defaults are checked on the first edge after each reset release.
`timescale 1ns/1ps
`default_nettype none
module osd_defaults_checker
(
	input wire logic       ref_clk,
	input wire logic       rst_b,
	input wire logic       clk_en,
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr_stb,
	input wire logic       space_code,
	input wire logic       scan_std_sel_hi,
	input wire logic       scan_std_sel_lo,
	input wire logic       out_polarity,
	input wire logic       osd_enable,
	input wire logic       hsync_in_polarity,
	input wire logic       vsync_in_polarity,
	input wire logic       shadow_mode_hi,
	input wire logic       shadow_mode_lo,
	input wire logic       blink_rate_hi,
	input wire logic       blink_rate_lo,
	input wire logic       blink_duty_hi,
	input wire logic       blink_duty_lo,
	input wire logic       port_ctrl,
	input wire logic [3:0] frame_bg,
	input wire logic       cmd_bank_hi,
	input wire logic       cmd_bank_lo,
	input wire logic       aux_attr_out,
	input wire logic [3:0] bg_attr,
	input wire logic       char_size_hi,
	input wire logic       char_size_lo,
	input wire logic       end_attr
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	// Defaults must already stand at the first edge after release
	a_ctrl1_default: assert property (
		$rose(rst_b) |-> !scan_std_sel_hi && !scan_std_sel_lo && out_polarity && !osd_enable)
		else $error("control 1 default wrong");
	a_ctrl2_default: assert property (
		$rose(rst_b) |-> {hsync_in_polarity, vsync_in_polarity, shadow_mode_hi, shadow_mode_lo} == 4'h1)
		else $error("control 2 default wrong");
	a_blink_default: assert property (
		$rose(rst_b) |-> {blink_rate_hi, blink_rate_lo, blink_duty_hi, blink_duty_lo} == 4'h0)
		else $error("blink default wrong");
	a_misc_default: assert property (
		$rose(rst_b) |-> !port_ctrl && frame_bg == 4'h2 && !cmd_bank_hi && !cmd_bank_lo)
		else $error("port, frame or bank default wrong");
	a_attr_default: assert property (
		$rose(rst_b) |-> {aux_attr_out, char_size_hi, char_size_lo, end_attr, bg_attr} == 8'h02)
		else $error("attribute default wrong");
	// Masked bits of a write land one cycle later
	a_ctrl1_write: assert property (
		clk_en && wr_stb && addr == osd_defaults_pkg::REG_CTRL1 |=>
		{4'h0, osd_enable, out_polarity, scan_std_sel_hi, scan_std_sel_lo} == ($past(wdata) & 8'h0F))
		else $error("control 1 write not applied");
	a_bank_hold: assert property (
		!(wr_stb && addr == osd_defaults_pkg::REG_BANK) |=> $stable({cmd_bank_hi, cmd_bank_lo}))
		else $error("bank changed without write");
	a_attr_hold: assert property (
		!space_code |=> $stable(bg_attr))
		else $error("background changed without code");
	c_write: cover property (wr_stb && addr == osd_defaults_pkg::REG_CTRL1);
	c_space: cover property (space_code);
	c_reset: cover property ($rose(rst_b));
endmodule
bind osd_reset_defaults osd_defaults_checker u_chk (.*);
`default_nettype wire

// file: osd_defaults_pkg.sv
// Purpose: Shared constants for the display controller's control and attribute bank.
// Assumes: Register indices and field layouts are internal choices of this design.
// Notes:   Reset values are the power-on defaults of each control field.
package osd_defaults_pkg;

	// Register indices on the plain register port
	localparam logic [2:0] REG_CTRL1  = 3'h0;
	localparam logic [2:0] REG_CTRL2  = 3'h1;
	localparam logic [2:0] REG_CTRL3  = 3'h2;
	localparam logic [2:0] REG_CTRL4  = 3'h3;
	localparam logic [2:0] REG_CTRL5  = 3'h4;
	localparam logic [2:0] REG_BANK   = 3'h5;
	localparam logic [2:0] REG_ATTR   = 3'h6;
	localparam logic [2:0] REG_STATUS = 3'h7;

	// Control register 1: [1:0] scan std, [2] out polarity, [3] enable
	localparam logic [7:0] CTRL1_RST  = 8'h04;
	// Control register 2: [0] hsync pol, [1] vsync pol, [3:2] shadow mode
	localparam logic [7:0] CTRL2_RST  = 8'h04;
	// Control register 3: [1:0] blink rate, [3:2] blink duty
	localparam logic [7:0] CTRL3_RST  = 8'h00;
	// Control register 4: [0] port control
	localparam logic [7:0] CTRL4_RST  = 8'h00;
	// Control register 5: frame colour [0] I, [1] B, [2] G, [3] R
	localparam logic [7:0] CTRL5_RST  = 8'h02;
	// Command bank: [1:0]
	localparam logic [7:0] BANK_RST   = 8'h00;

	localparam logic [7:0] CTRL1_MASK = 8'h0F;
	localparam logic [7:0] CTRL2_MASK = 8'h0F;
	localparam logic [7:0] CTRL3_MASK = 8'h0F;
	localparam logic [7:0] CTRL4_MASK = 8'h01;
	localparam logic [7:0] CTRL5_MASK = 8'h0F;
	localparam logic [7:0] BANK_MASK  = 8'h03;

	// Field positions
	localparam int CTRL1_POL_BIT = 2;
	localparam int CTRL1_EN_BIT  = 3;
	localparam int SCAN_LO_BIT   = 0;
	localparam int SCAN_HI_BIT   = 1;
	localparam int HPOL_BIT      = 0;
	localparam int VPOL_BIT      = 1;
	localparam int SHADOW_LO_BIT = 2;
	localparam int SHADOW_HI_BIT = 3;
	localparam int RATE_LO_BIT   = 0;
	localparam int RATE_HI_BIT   = 1;
	localparam int DUTY_LO_BIT   = 2;
	localparam int DUTY_HI_BIT   = 3;
	localparam int PORT_BIT      = 0;
	localparam int COLOUR_HI_BIT = 3;
	localparam int BANK_LO_BIT   = 0;
	localparam int BANK_HI_BIT   = 1;

	// Shared pin level while reset is held
	localparam logic PIN_RST     = 1'h0;

	// Attribute layout: [3:0] bg colour (I,B,G,R), [4] aux, [6:5] size, [7] end
	localparam logic [3:0] ATTR_BG_RST   = 4'h2;
	localparam logic       ATTR_AUX_RST  = 1'h0;
	localparam logic [1:0] ATTR_SIZE_RST = 2'h0;
	localparam logic       ATTR_END_RST  = 1'h0;

	localparam logic [7:0] READ_IDLE = 8'h00;

endpackage

// file: osd_reset_defaults.sv
// Purpose: Control and attribute bank of the on-screen display controller.
// Assumes: Host reaches registers over a plain strobe port; one clock, ref_clk.
// Notes:   Register indices are eight-bit wide words at indices 0 to 7.
//          Unused bits are not stored and read back as zero.
//          Attribute and status indices are read-only; writes to them are dropped.
//          A low clock enable freezes every flop, the read data and the pin included.
//
// Contract
// - Reset clears both scan standard bits, selecting conventional scanning.
// - Reset sets output polarity to one: colour and blank outputs active high.
// - Reset clears display enable; display stays off until host enables.
// - Reset clears hsync input polarity: hsync input active low.
// - Reset clears vsync input polarity: vsync input active low.
// - Reset loads shadow mode high zero, low one: north-west shadowing.
// - Reset clears blink rate bits: blink at vsync rate over sixteen.
// - Reset clears blink duty bits: three to one active ratio.
// - Reset clears port control: shared aux pin is a general output port.
// - Reset sets frame background colour to blue only.
// - Reset clears command bank bits: commands decoded in bank zero.
// - Reset holds aux attribute low until a space code changes it.
// - Reset sets background attribute to blue until a space code changes it.
// - Reset clears character size: single height and width until return code.
// - Reset clears end-of-display: keep fetching next characters.
//
// The placing of the registers and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module osd_reset_defaults
(
	input  wire logic       ref_clk,
	input  wire logic       rst_b,
	input  wire logic       clk_en,
	// Register port
	input  wire logic [2:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr_stb,
	input  wire logic       rd_stb,
	// Display code strobes and their operands
	input  wire logic       space_code,
	input  wire logic       space_aux,
	input  wire logic [3:0] space_bg,
	input  wire logic       return_code,
	input  wire logic [1:0] return_size,
	input  wire logic       end_code,
	input  wire logic       frame_start,
	// Level for the shared pin in port mode
	input  wire logic       port_data,
	// Read data stand one cycle after the strobe
	output var  logic [7:0] rdata,
	// Host-written control fields
	output var  logic       scan_std_sel_hi,
	output var  logic       scan_std_sel_lo,
	output var  logic       out_polarity,
	output var  logic       osd_enable,
	output var  logic       hsync_in_polarity,
	output var  logic       vsync_in_polarity,
	output var  logic       shadow_mode_hi,
	output var  logic       shadow_mode_lo,
	output var  logic       blink_rate_hi,
	output var  logic       blink_rate_lo,
	output var  logic       blink_duty_hi,
	output var  logic       blink_duty_lo,
	output var  logic       port_ctrl,
	output var  logic [3:0] frame_bg,
	output var  logic       cmd_bank_hi,
	output var  logic       cmd_bank_lo,
	// Attributes changed only by display codes
	output var  logic       aux_attr_out,
	output var  logic [3:0] bg_attr,
	output var  logic       char_size_hi,
	output var  logic       char_size_lo,
	output var  logic       end_attr,
	// Shared auxiliary pin, one cycle behind its source
	output var  logic       shared_aux_pin
);

	// Stored words of the host-written registers
	logic [7:0] ctrl1;
	logic [7:0] ctrl2;
	logic [7:0] ctrl3;
	logic [7:0] ctrl4;
	logic [7:0] ctrl5;
	logic [7:0] bank;
	// Read path and shared pin
	logic [7:0] next_rdata;
	logic       next_pin;
	// Attribute flops held in the code-driven bank
	logic       aux_q;
	logic [3:0] bg_q;
	logic       size_hi_q;
	logic       size_lo_q;
	logic       end_q;

	// One-hot write select, used by every register instance
	// An index with no register matches no instance, so such a write is dropped
	function automatic logic wsel(input logic [2:0] a, input logic [2:0] idx, input logic w);
		wsel = w && (a == idx);
	endfunction

	// Host-written control registers with their power-on defaults
	osd_ctrl_reg #(.RST_VAL(osd_defaults_pkg::CTRL1_RST), .MASK(osd_defaults_pkg::CTRL1_MASK))
	u_ctrl1
	(
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.clk_en  (clk_en),
		.wr      (wsel(addr, osd_defaults_pkg::REG_CTRL1, wr_stb)),
		.wdata   (wdata),
		.value   (ctrl1)
	);

	// Sync polarities and shadow mode
	osd_ctrl_reg #(.RST_VAL(osd_defaults_pkg::CTRL2_RST), .MASK(osd_defaults_pkg::CTRL2_MASK))
	u_ctrl2
	(
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.clk_en  (clk_en),
		.wr      (wsel(addr, osd_defaults_pkg::REG_CTRL2, wr_stb)),
		.wdata   (wdata),
		.value   (ctrl2)
	);

	// Blink rate and duty
	osd_ctrl_reg #(.RST_VAL(osd_defaults_pkg::CTRL3_RST), .MASK(osd_defaults_pkg::CTRL3_MASK))
	u_ctrl3
	(
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.clk_en  (clk_en),
		.wr      (wsel(addr, osd_defaults_pkg::REG_CTRL3, wr_stb)),
		.wdata   (wdata),
		.value   (ctrl3)
	);

	// Port or display function of the shared pin
	osd_ctrl_reg #(.RST_VAL(osd_defaults_pkg::CTRL4_RST), .MASK(osd_defaults_pkg::CTRL4_MASK))
	u_ctrl4
	(
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.clk_en  (clk_en),
		.wr      (wsel(addr, osd_defaults_pkg::REG_CTRL4, wr_stb)),
		.wdata   (wdata),
		.value   (ctrl4)
	);

	// Frame shadowing background colour
	osd_ctrl_reg #(.RST_VAL(osd_defaults_pkg::CTRL5_RST), .MASK(osd_defaults_pkg::CTRL5_MASK))
	u_ctrl5
	(
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.clk_en  (clk_en),
		.wr      (wsel(addr, osd_defaults_pkg::REG_CTRL5, wr_stb)),
		.wdata   (wdata),
		.value   (ctrl5)
	);

	// Command bank select
	osd_ctrl_reg #(.RST_VAL(osd_defaults_pkg::BANK_RST), .MASK(osd_defaults_pkg::BANK_MASK))
	u_bank
	(
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.clk_en  (clk_en),
		.wr      (wsel(addr, osd_defaults_pkg::REG_BANK, wr_stb)),
		.wdata   (wdata),
		.value   (bank)
	);

	// Attributes that only display codes can change
	// Frame start clears the end mark so every frame fetches from its first code
	osd_attr_state u_attr
	(
		.ref_clk      (ref_clk),
		.rst_b        (rst_b),
		.clk_en       (clk_en),
		.space_code   (space_code),
		.space_aux    (space_aux),
		.space_bg     (space_bg),
		.return_code  (return_code),
		.return_size  (return_size),
		.end_code     (end_code),
		.restart      (frame_start),
		.aux_attr_out (aux_q),
		.bg_attr      (bg_q),
		.char_size_hi (size_hi_q),
		.char_size_lo (size_lo_q),
		.end_attr     (end_q)
	);

	// Control register 1: scan standard, output polarity and enable
	// Polarity also steers the shared pin while it carries the attribute
	always_comb
	begin
		scan_std_sel_hi = ctrl1[osd_defaults_pkg::SCAN_HI_BIT];
		scan_std_sel_lo = ctrl1[osd_defaults_pkg::SCAN_LO_BIT];
		out_polarity    = ctrl1[osd_defaults_pkg::CTRL1_POL_BIT];
		osd_enable      = ctrl1[osd_defaults_pkg::CTRL1_EN_BIT];
	end

	// Control register 2: sync input polarities and shadow mode
	always_comb
	begin
		hsync_in_polarity = ctrl2[osd_defaults_pkg::HPOL_BIT];
		vsync_in_polarity = ctrl2[osd_defaults_pkg::VPOL_BIT];
		shadow_mode_lo    = ctrl2[osd_defaults_pkg::SHADOW_LO_BIT];
		shadow_mode_hi    = ctrl2[osd_defaults_pkg::SHADOW_HI_BIT];
	end

	// Control register 3: blink rate and duty
	// Only the settings live here; the blink timer belongs to the display path
	always_comb
	begin
		blink_rate_lo = ctrl3[osd_defaults_pkg::RATE_LO_BIT];
		blink_rate_hi = ctrl3[osd_defaults_pkg::RATE_HI_BIT];
		blink_duty_lo = ctrl3[osd_defaults_pkg::DUTY_LO_BIT];
		blink_duty_hi = ctrl3[osd_defaults_pkg::DUTY_HI_BIT];
	end

	// Control register 4: function of the shared pin
	always_comb
	begin
		port_ctrl = ctrl4[osd_defaults_pkg::PORT_BIT];
	end

	// Control register 5: frame shadowing background colour
	always_comb
	begin
		frame_bg = ctrl5[osd_defaults_pkg::COLOUR_HI_BIT:0];
	end

	// Command bank select
	always_comb
	begin
		cmd_bank_lo = bank[osd_defaults_pkg::BANK_LO_BIT];
		cmd_bank_hi = bank[osd_defaults_pkg::BANK_HI_BIT];
	end

	// Code-driven attributes, copied from the flops of the attribute bank
	// Software can read these bits but has no way to write them
	always_comb
	begin
		aux_attr_out = aux_q;
		bg_attr      = bg_q;
		char_size_hi = size_hi_q;
		char_size_lo = size_lo_q;
		end_attr     = end_q;
	end

	// Read mux; the idle value between reads keeps stale data off the bus
	// Indices 0 to 5 echo the stored words, masked bits reading as zero
	always_comb
	begin
		next_rdata = osd_defaults_pkg::READ_IDLE;
		if (rd_stb)
		begin
			unique case (addr)
				osd_defaults_pkg::REG_CTRL1:  next_rdata = ctrl1;
				osd_defaults_pkg::REG_CTRL2:  next_rdata = ctrl2;
				osd_defaults_pkg::REG_CTRL3:  next_rdata = ctrl3;
				osd_defaults_pkg::REG_CTRL4:  next_rdata = ctrl4;
				osd_defaults_pkg::REG_CTRL5:  next_rdata = ctrl5;
				osd_defaults_pkg::REG_BANK:   next_rdata = bank;
				// Attribute word mirrors the code-driven flops for diagnostics
				osd_defaults_pkg::REG_ATTR:   next_rdata = {end_q, size_hi_q, size_lo_q, aux_q, bg_q};
				// Status shows the pin as driven, not as seen on the board
				osd_defaults_pkg::REG_STATUS: next_rdata = {7'h00, shared_aux_pin};
			endcase
		end
	end

	// Port mode drives plain data; display mode drives the aux attribute in polarity
	always_comb
	begin
		if (ctrl4[osd_defaults_pkg::PORT_BIT])
			next_pin = aux_q ~^ ctrl1[osd_defaults_pkg::CTRL1_POL_BIT];
		else
			next_pin = port_data;
	end

	// Read data stand only in the cycle after the strobe
	// A frozen clock enable keeps the last word on the bus
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			rdata <= osd_defaults_pkg::READ_IDLE;
		else if (clk_en)
			rdata <= next_rdata;
	end

	// Registered so the pin cannot glitch while the mode bit changes
	// The cost is one cycle of delay behind port data or the attribute
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			shared_aux_pin <= osd_defaults_pkg::PIN_RST;
		else if (clk_en)
			shared_aux_pin <= next_pin;
	end

endmodule
`default_nettype wire

// file: testbench.sv
// Purpose: Self-checking bench for the control and attribute bank.
// Assumes: Host model drives the register port; bench drives the rest.
// Notes:   Outputs are sampled 1 ns after an edge to avoid races.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic       ref_clk, rst_b, clk_en, space_code, space_aux, return_code;
	logic       end_code, frame_start, port_data, wr_stb, rd_stb, port_ctrl;
	logic       scan_std_sel_hi, scan_std_sel_lo, out_polarity, osd_enable;
	logic       hsync_in_polarity, vsync_in_polarity, shadow_mode_hi, shadow_mode_lo;
	logic       blink_rate_hi, blink_rate_lo, blink_duty_hi, blink_duty_lo;
	logic       cmd_bank_hi, cmd_bank_lo, aux_attr_out, char_size_hi, char_size_lo;
	logic       end_attr, shared_aux_pin;
	logic [1:0] return_size;
	logic [2:0] addr;
	logic [3:0] space_bg, frame_bg, bg_attr;
	logic [7:0] wdata, rdata, rd_val;
	int         num_errors, comparisons, cycles;
	osd_reset_defaults DUT (.*);
	host_model host (.*);
	// Free-running 50 MHz clock
	initial
	begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic complete_run;
		if (num_errors == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// A hang is cut short well beyond the roughly 70 cycles needed
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			num_errors++;
			complete_run();
		end
	end
	// Pins and every readable register after a reset
	task automatic check_defaults;
		logic [7:0] exp_reg [8];
		exp_reg = '{8'h04, 8'h04, 8'h00, 8'h00, 8'h02, 8'h00, 8'h02, 8'h00};
		@(posedge ref_clk);
		#1;
		chk({scan_std_sel_hi, scan_std_sel_lo, out_polarity, osd_enable,
			hsync_in_polarity, vsync_in_polarity, shadow_mode_hi, shadow_mode_lo}, 8'h21);
		chk({blink_rate_hi, blink_rate_lo, blink_duty_hi, blink_duty_lo,
			port_ctrl, cmd_bank_hi, cmd_bank_lo, aux_attr_out}, 8'h00);
		chk({frame_bg, bg_attr}, 8'h22);
		chk({4'h0, char_size_hi, char_size_lo, end_attr, shared_aux_pin}, 8'h00);
		for (int i = 0; i < 8; i++)
		begin
			host.rd(3'(i), rd_val);
			chk(rd_val, exp_reg[i]);
		end
	endtask
	// Writes one idle cycle apart, masked bits, a read-only index
	task automatic write_masking;
		host.wr(osd_defaults_pkg::REG_CTRL1, 8'hFB);
		host.wr(osd_defaults_pkg::REG_BANK, 8'hFF);
		host.wr(osd_defaults_pkg::REG_ATTR, 8'h00);
		host.wr(osd_defaults_pkg::REG_CTRL4, 8'hFF);
		#1;
		chk({4'h0, scan_std_sel_hi, scan_std_sel_lo, out_polarity, osd_enable}, 8'h0D);
		chk({5'h0, cmd_bank_hi, cmd_bank_lo, port_ctrl}, 8'h07);
		host.rd(osd_defaults_pkg::REG_CTRL1, rd_val);
		chk(rd_val, 8'h0B);
		host.rd(osd_defaults_pkg::REG_ATTR, rd_val);
		chk(rd_val, 8'h02);
		chk({7'h0, shared_aux_pin}, 8'h01);
	endtask
	// Display codes change only the attributes they name
	task automatic code_updates;
		@(posedge ref_clk);
		space_code <= 1'b1;
		space_aux <= 1'b1;
		space_bg <= 4'h8;
		return_code <= 1'b1;
		return_size <= 2'h2;
		end_code <= 1'b1;
		@(posedge ref_clk);
		space_code <= 1'b0;
		return_code <= 1'b0;
		end_code <= 1'b0;
		space_bg <= 4'h7;
		#1;
		chk({aux_attr_out, char_size_hi, char_size_lo, end_attr, bg_attr}, 8'hD8);
		@(posedge ref_clk);
		frame_start <= 1'b1;
		#1;
		chk({7'h0, shared_aux_pin}, 8'h00);
		@(posedge ref_clk);
		frame_start <= 1'b0;
		#1;
		chk({aux_attr_out, char_size_hi, char_size_lo, end_attr, bg_attr}, 8'hC8);
	endtask
	// Frozen clock enable drops a write; port mode then passes port data to the pin
	task automatic freeze_and_port;
		@(posedge ref_clk);
		clk_en <= 1'b0;
		host.wr(osd_defaults_pkg::REG_CTRL5, 8'hFC);
		@(posedge ref_clk);
		clk_en <= 1'b1;
		#1;
		chk({4'h0, frame_bg}, 8'h02);
		host.wr(osd_defaults_pkg::REG_CTRL5, 8'hFC);
		host.wr(osd_defaults_pkg::REG_CTRL4, 8'h00);
		port_data <= 1'b1;
		@(posedge ref_clk);
		#1;
		chk({frame_bg, 3'h0, shared_aux_pin}, 8'hC1);
		host.rd(osd_defaults_pkg::REG_STATUS, rd_val);
		chk(rd_val, 8'h01);
		@(posedge ref_clk);
		port_data <= 1'b0;
		#1;
		chk(rdata, 8'h00);
	endtask
	initial
	begin
		rst_b = 1'b0;
		clk_en = 1'b1;
		space_code = 1'b0;
		space_aux = 1'b0;
		space_bg = 4'h0;
		return_code = 1'b0;
		return_size = 2'h0;
		end_code = 1'b0;
		frame_start = 1'b0;
		port_data = 1'b0;
		repeat (6) @(posedge ref_clk);
		rst_b <= 1'b1;
		check_defaults();
		write_masking();
		code_updates();
		freeze_and_port();
		// Second reset in mid-run must restore every default
		@(posedge ref_clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_b <= 1'b1;
		check_defaults();
		complete_run();
	end
endmodule
`default_nettype wire
